/* ssf_baud_gen.sv */
// baud generator: 4^n prescaler then divisor, giving the 16x oversample tick
`default_nettype none
module ssf_baud_gen #(
    parameter int DIV_W = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             srcTick,
    input  wire logic [DIV_W-1:0] divisor,
    input  wire logic [1:0]       exponent,
    output logic                  ovsTick
);
    logic [5:0]       preCnt_ff;
    logic [5:0]       nxt_preCnt;
    logic [5:0]       preLast;
    logic             preTick;
    logic [DIV_W-1:0] divCnt_ff;
    logic [DIV_W-1:0] nxt_divCnt;
    logic             ovsTick_ff;
    logic             nxt_ovsTick;

    always_comb begin
        case (exponent)
            2'h0:    preLast = 6'h00;
            2'h1:    preLast = 6'h03;
            2'h2:    preLast = 6'h0F;
            default: preLast = 6'h3F;
        endcase
        // at or past the end, so a smaller exponent never waits for a full wrap
        preTick     = srcTick && (preCnt_ff >= preLast);
        nxt_preCnt  = preCnt_ff;
        nxt_divCnt  = divCnt_ff;
        nxt_ovsTick = 1'b0;
        if (srcTick) begin
            nxt_preCnt = preTick ? 6'h00 : preCnt_ff + 6'h01;
        end
        if (preTick) begin
            if (divCnt_ff == divisor) begin
                nxt_divCnt  = '0;
                nxt_ovsTick = 1'b1;
            end else begin
                nxt_divCnt = divCnt_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            preCnt_ff  <= 6'h00;
            divCnt_ff  <= '0;
            ovsTick_ff <= 1'b0;
        end else begin
            preCnt_ff  <= nxt_preCnt;
            divCnt_ff  <= nxt_divCnt;
            ovsTick_ff <= nxt_ovsTick;
        end
    end

    assign ovsTick = ovsTick_ff;

    property p_exp_zero_passes;
        @(posedge clk) disable iff (!rst_b)
        (exponent == 2'h0 && srcTick && divisor == '0) |=> ovsTick;
    endproperty
    a_exp_zero_passes: assert property (p_exp_zero_passes) else $error("exponent zero tick lost");
endmodule : ssf_baud_gen
`default_nettype wire

/* ssf_consts.svh */
// register offsets, field positions, reset values and timing counts of the frame format block
`ifndef SSF_CONSTS_SVH
`define SSF_CONSTS_SVH

`define SSF_OFF_MODE    8'h00
`define SSF_OFF_CTRL    8'h04
`define SSF_OFF_DIV     8'h08
`define SSF_OFF_DATA    8'h0C
`define SSF_OFF_STAT    8'h10
`define SSF_OFF_CLR     8'h14
`define SSF_OFF_IEN     8'h18

`define SSF_MODE_SYNC   7
`define SSF_MODE_CHR7   6
`define SSF_MODE_PARITY_ENABLE 5
`define SSF_MODE_ODD    4
`define SSF_MODE_STOP2  3
`define SSF_MODE_FIVE_BIT_FORMAT 2
`define SSF_MODE_BAUD_CLOCK_SELECT_HI 1
`define SSF_MODE_BAUD_CLOCK_SELECT_LO 0

`define SSF_CTRL_TXEN   0
`define SSF_CTRL_RXEN   1
`define SSF_CTRL_SUBACT 2
`define SSF_CTRL_CPUSUB 3
`define SSF_CTRL_TXPEND 4
`define SSF_CTRL_RXBUSY 5

`define SSF_ST_TXDONE   0
`define SSF_ST_RXDONE   1
`define SSF_ST_PERR     2
`define SSF_ST_FERR     3

`define SSF_MODE_RST    8'h00
`define SSF_CTRL_RST    4'h0
`define SSF_DIV_RST     8'h00
`define SSF_TXBUF_RST   8'hFF
`define SSF_OVS_LAST    4'hF
`define SSF_OVS_MID     4'h7
`define SSF_LEN_FIVE    4'h5
`define SSF_LEN_SEVEN   4'h7
`define SSF_LEN_EIGHT   4'h8

`endif

/* ssf_pkg.sv */
// types shared by the frame format block
`default_nettype none
package ssf_pkg;
    typedef enum logic [2:0] {
        TX_IDLE  = 3'b000,
        TX_START = 3'b001,
        TX_DATA  = 3'b010,
        TX_PAR   = 3'b011,
        TX_STOP1 = 3'b100,
        TX_STOP2 = 3'b101
    } ssf_tx_t;
    typedef enum logic [2:0] {
        RX_IDLE  = 3'b000,
        RX_START = 3'b001,
        RX_DATA  = 3'b010,
        RX_PAR   = 3'b011,
        RX_STOP  = 3'b100
    } ssf_rx_t;
    typedef enum logic [1:0] {
        CKS_SYS  = 2'b00,
        CKS_SUB  = 2'b01,
        CKS_RES2 = 2'b10,
        CKS_RES3 = 2'b11
    } ssf_cks_t;
endpackage : ssf_pkg
`default_nettype wire

/* ssf_station.sv */
// remote serial station model: sends frames on rxd and samples frames from txd
`default_nettype none
module ssf_station (
    input  wire logic clk,
    input  wire logic txd,
    output var logic  rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rxd = 1'b1;
    // lsb first, 16 clocks a bit, line returns to idle high; caller picks stop count and parity bit
    task automatic send(input logic [23:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            rxd <= bits[i];
            repeat (16) @(posedge clk);
        end
        rxd <= 1'b1;
    endtask : send
    // mid-bit sampling from the start edge; a missing start leaves garbage for the caller to catch
    task automatic grab(input int n, output logic [15:0] bits);
        bits = '0;
        for (int w = 0; w < 300 && txd !== 1'b0; w++) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            repeat (i == 0 ? 8 : 16) @(posedge clk);
            bits[i] = txd;
        end
    endtask : grab
endmodule : ssf_station
`default_nettype wire

/* ssf_top.sv */
// frame format, parity, stop length and baud clock select of the serial unit, with wishbone slave
// Behaviour
// - parity sense bit clear gives even parity, set gives odd; async with parity only.
// - even parity: transmitted ones plus parity bit even; receiver checks it is even.
// - odd parity: transmitted ones plus parity bit odd; receiver checks it is odd.
// - parity sense ignored whenever parity is off, in either mode.
// - async transmit uses one stop bit when stop field clear, two when set.
// - receiver checks only the first stop bit for framing.
// - a low bit after the first stop bit is the next start bit.
// - five-bit format field enables five data bits when async parity is on.
// - select 01 feeds subclock/2 in active, subclock in subactive; exponent one.
// - subclock source only works while the CPU runs from subclock/2.
// - clock select value is the prescaler exponent used with the divisor.
// - parity enable adds and checks parity in async only; never in sync.
// - five bits need parity enable and five-bit format; top three bits dropped.
`include "ssf_consts.svh"
`default_nettype none
module ssf_top #(
    parameter int ADR_W = 8,
    parameter int DIV_W = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic [31:0]           wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic             subTick,
    input  wire logic             rxd,
    output logic                  txd,
    output logic                  irq
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0]       mode_ff, nxt_mode;
    logic [3:0]       ctrl_ff, nxt_ctrl;
    logic [DIV_W-1:0] div_ff, nxt_div;
    logic [3:0]       sts_ff, nxt_sts;
    logic [3:0]       ien_ff, nxt_ien;
    logic [7:0]       txBuf_ff, nxt_txBuf;
    logic             txPend_ff, nxt_txPend;
    logic [7:0]       rxData_ff, nxt_rxData;
    logic             ack_ff, nxt_ack;
    logic [31:0]      datO_ff, nxt_datO;
    logic             irq_ff, nxt_irq;
    logic             subHalf_ff, nxt_subHalf;
    logic             busReq, busWr, rxBusy;
    logic             srcTick, ovsTick;
    logic             txTake, txDone, rxDone, rxPerr, rxFerr;
    logic             frmParOn, frmFive;
    logic [3:0]       frmLen;
    ssf_pkg::ssf_cks_t cks;

    assign busReq = wb_cyc_i && wb_stb_i && !ack_ff;
    assign busWr  = busReq && wb_we_i && wb_sel_i[0];
    assign cks    = ssf_pkg::ssf_cks_t'(mode_ff[`SSF_MODE_BAUD_CLOCK_SELECT_HI:`SSF_MODE_BAUD_CLOCK_SELECT_LO]);

    // frame shape as the mode register asks for it
    always_comb begin
        frmParOn = mode_ff[`SSF_MODE_PARITY_ENABLE] && !mode_ff[`SSF_MODE_SYNC];
        // five bits only with parity enable too, which software sets in the same write
        frmFive  = frmParOn && mode_ff[`SSF_MODE_FIVE_BIT_FORMAT];
        if (frmFive) begin
            frmLen = `SSF_LEN_FIVE;
        end else if (mode_ff[`SSF_MODE_CHR7] && !mode_ff[`SSF_MODE_SYNC]) begin
            frmLen = `SSF_LEN_SEVEN;
        end else begin
            frmLen = `SSF_LEN_EIGHT;
        end
    end

    // reserved selects give no tick at all so the generator is frozen, not random
    always_comb begin
        nxt_subHalf = subTick ? !subHalf_ff : subHalf_ff;
        case (cks)
            ssf_pkg::CKS_SYS: srcTick = 1'b1;
            ssf_pkg::CKS_SUB: srcTick = ctrl_ff[`SSF_CTRL_CPUSUB] && subTick
                                        && (ctrl_ff[`SSF_CTRL_SUBACT] || subHalf_ff);
            default:          srcTick = 1'b0;
        endcase
    end

    ssf_baud_gen #(.DIV_W(DIV_W)) u_baud (
        .clk      (clk),
        .rst_b    (rst_b),
        .srcTick  (srcTick),
        .divisor  (div_ff),
        .exponent (mode_ff[`SSF_MODE_BAUD_CLOCK_SELECT_HI:`SSF_MODE_BAUD_CLOCK_SELECT_LO]),
        .ovsTick  (ovsTick)
    );

    ////////////////////////////////////////////////////////////////////////
    // register file and wishbone answer
    always_comb begin
        nxt_mode   = mode_ff;
        nxt_ctrl   = ctrl_ff;
        nxt_div    = div_ff;
        nxt_ien    = ien_ff;
        nxt_txBuf  = txBuf_ff;
        nxt_txPend = txPend_ff && !txTake;
        nxt_ack    = busReq;
        nxt_datO   = 32'h0000_0000;
        nxt_sts    = sts_ff;
        if (busWr) begin
            case (wb_adr_i)
                `SSF_OFF_MODE: nxt_mode = wb_dat_i[7:0];
                `SSF_OFF_CTRL: nxt_ctrl = wb_dat_i[3:0];
                `SSF_OFF_DIV:  nxt_div  = wb_dat_i[DIV_W-1:0];
                `SSF_OFF_IEN:  nxt_ien  = wb_dat_i[3:0];
                `SSF_OFF_CLR:  nxt_sts  = sts_ff & ~wb_dat_i[3:0];
                `SSF_OFF_DATA: begin
                    // a write while a byte is still pending is dropped
                    if (!txPend_ff) begin
                        nxt_txBuf  = wb_dat_i[7:0];
                        nxt_txPend = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        // set wins over a clear in the same cycle
        nxt_sts = nxt_sts | {rxFerr, rxPerr, rxDone, txDone};
        if (busReq && !wb_we_i) begin
            case (wb_adr_i)
                `SSF_OFF_MODE: nxt_datO[7:0] = mode_ff;
                `SSF_OFF_CTRL: nxt_datO[5:0] = {rxBusy, txPend_ff, ctrl_ff};
                `SSF_OFF_DIV:  nxt_datO[DIV_W-1:0] = div_ff;
                `SSF_OFF_DATA: nxt_datO[7:0] = rxData_ff;
                `SSF_OFF_STAT: nxt_datO[3:0] = sts_ff;
                `SSF_OFF_IEN:  nxt_datO[3:0] = ien_ff;
                default: ;
            endcase
        end
        nxt_irq = |(sts_ff & ien_ff);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mode_ff    <= `SSF_MODE_RST;
            ctrl_ff    <= `SSF_CTRL_RST;
            div_ff     <= `SSF_DIV_RST;
            ien_ff     <= 4'h0;
            sts_ff     <= 4'h0;
            txBuf_ff   <= `SSF_TXBUF_RST;
            txPend_ff  <= 1'b0;
            ack_ff     <= 1'b0;
            datO_ff    <= 32'h0000_0000;
            irq_ff     <= 1'b0;
            subHalf_ff <= 1'b0;
        end else begin
            mode_ff    <= nxt_mode;
            ctrl_ff    <= nxt_ctrl;
            div_ff     <= nxt_div;
            ien_ff     <= nxt_ien;
            sts_ff     <= nxt_sts;
            txBuf_ff   <= nxt_txBuf;
            txPend_ff  <= nxt_txPend;
            ack_ff     <= nxt_ack;
            datO_ff    <= nxt_datO;
            irq_ff     <= nxt_irq;
            subHalf_ff <= nxt_subHalf;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = datO_ff;
    assign irq      = irq_ff;

    ////////////////////////////////////////////////////////////////////////
    // transmitter; frame shape is latched at the start bit, so a mode write mid-frame can change only the bit rate, through clock select
    ssf_pkg::ssf_tx_t txState_ff, nxt_txState;
    logic [3:0] txOvs_ff, nxt_txOvs, txCnt_ff, nxt_txCnt, txLen_ff, nxt_txLen;
    logic [7:0] txShift_ff, nxt_txShift;
    logic       txOnes_ff, nxt_txOnes, txOdd_ff, nxt_txOdd, txParOn_ff, nxt_txParOn;
    logic       txStop2_ff, nxt_txStop2, txd_ff, nxt_txd, txBitEnd;

    always_comb begin
        nxt_txState = txState_ff;
        nxt_txOvs   = (ovsTick && txState_ff != ssf_pkg::TX_IDLE) ? txOvs_ff + 4'h1 : txOvs_ff;
        nxt_txCnt   = txCnt_ff;
        nxt_txLen   = txLen_ff;
        nxt_txShift = txShift_ff;
        nxt_txOnes  = txOnes_ff;
        nxt_txOdd   = txOdd_ff;
        nxt_txParOn = txParOn_ff;
        nxt_txStop2 = txStop2_ff;
        txTake      = 1'b0;
        txDone      = 1'b0;
        txBitEnd    = ovsTick && txOvs_ff == `SSF_OVS_LAST;
        case (txState_ff)
            ssf_pkg::TX_IDLE: begin
                if (txPend_ff && ctrl_ff[`SSF_CTRL_TXEN]) begin
                    txTake      = 1'b1;
                    nxt_txState = ssf_pkg::TX_START;
                    nxt_txOvs   = 4'h0;
                    nxt_txCnt   = 4'h0;
                    nxt_txOnes  = 1'b0;
                    nxt_txShift = txBuf_ff; // high bits beyond the length are never shifted out
                    nxt_txLen   = frmLen;
                    nxt_txParOn = frmParOn;
                    nxt_txOdd   = mode_ff[`SSF_MODE_ODD];
                    nxt_txStop2 = mode_ff[`SSF_MODE_STOP2] && !mode_ff[`SSF_MODE_SYNC];
                end
            end
            ssf_pkg::TX_START: if (txBitEnd) nxt_txState = ssf_pkg::TX_DATA;
            ssf_pkg::TX_DATA: begin
                if (txBitEnd) begin
                    nxt_txOnes  = txOnes_ff ^ txShift_ff[0];
                    nxt_txShift = {1'b1, txShift_ff[7:1]};
                    nxt_txCnt   = txCnt_ff + 4'h1;
                    if (txCnt_ff == txLen_ff - 4'h1) begin
                        nxt_txState = txParOn_ff ? ssf_pkg::TX_PAR : ssf_pkg::TX_STOP1;
                    end
                end
            end
            ssf_pkg::TX_PAR: if (txBitEnd) nxt_txState = ssf_pkg::TX_STOP1;
            ssf_pkg::TX_STOP1: begin
                if (txBitEnd) begin
                    nxt_txState = txStop2_ff ? ssf_pkg::TX_STOP2 : ssf_pkg::TX_IDLE;
                    txDone      = !txStop2_ff;
                end
            end
            ssf_pkg::TX_STOP2: begin
                if (txBitEnd) begin
                    nxt_txState = ssf_pkg::TX_IDLE;
                    txDone      = 1'b1;
                end
            end
            default: nxt_txState = ssf_pkg::TX_IDLE;
        endcase
        case (nxt_txState)
            ssf_pkg::TX_START: nxt_txd = 1'b0;
            ssf_pkg::TX_DATA:  nxt_txd = nxt_txShift[0];
            ssf_pkg::TX_PAR:   nxt_txd = nxt_txOnes ^ nxt_txOdd;
            default:           nxt_txd = 1'b1;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            txState_ff <= ssf_pkg::TX_IDLE;
            txOvs_ff   <= 4'h0;
            txCnt_ff   <= 4'h0;
            txLen_ff   <= `SSF_LEN_EIGHT;
            txShift_ff <= 8'hFF;
            txOnes_ff  <= 1'b0;
            txOdd_ff   <= 1'b0;
            txParOn_ff <= 1'b0;
            txStop2_ff <= 1'b0;
            txd_ff     <= 1'b1;
        end else begin
            txState_ff <= nxt_txState;
            txOvs_ff   <= nxt_txOvs;
            txCnt_ff   <= nxt_txCnt;
            txLen_ff   <= nxt_txLen;
            txShift_ff <= nxt_txShift;
            txOnes_ff  <= nxt_txOnes;
            txOdd_ff   <= nxt_txOdd;
            txParOn_ff <= nxt_txParOn;
            txStop2_ff <= nxt_txStop2;
            txd_ff     <= nxt_txd;
        end
    end

    assign txd = txd_ff;

    ////////////////////////////////////////////////////////////////////////
    // receiver, sampling at mid bit on the 16x tick
    ssf_pkg::ssf_rx_t rxState_ff, nxt_rxState;
    logic [3:0] rxOvs_ff, nxt_rxOvs, rxCnt_ff, nxt_rxCnt, rxLen_ff, nxt_rxLen;
    logic [7:0] rxShift_ff, nxt_rxShift;
    logic       rxOnes_ff, nxt_rxOnes, rxOdd_ff, nxt_rxOdd, rxParOn_ff, nxt_rxParOn;
    logic       rxSample;

    assign rxBusy = rxState_ff != ssf_pkg::RX_IDLE;

    always_comb begin
        nxt_rxState = rxState_ff;
        nxt_rxOvs   = (ovsTick && rxBusy) ? rxOvs_ff + 4'h1 : rxOvs_ff;
        nxt_rxCnt   = rxCnt_ff;
        nxt_rxLen   = rxLen_ff;
        nxt_rxShift = rxShift_ff;
        nxt_rxOnes  = rxOnes_ff;
        nxt_rxOdd   = rxOdd_ff;
        nxt_rxParOn = rxParOn_ff;
        nxt_rxData  = rxData_ff;
        rxDone      = 1'b0;
        rxPerr      = 1'b0;
        rxFerr      = 1'b0;
        rxSample    = ovsTick && rxOvs_ff == `SSF_OVS_LAST;
        case (rxState_ff)
            ssf_pkg::RX_IDLE: begin
                if (ctrl_ff[`SSF_CTRL_RXEN] && ovsTick && !rxd) begin
                    nxt_rxState = ssf_pkg::RX_START;
                    nxt_rxOvs   = 4'h0;
                    nxt_rxCnt   = 4'h0;
                    nxt_rxOnes  = 1'b0;
                    nxt_rxLen   = frmLen;
                    nxt_rxParOn = frmParOn;
                    nxt_rxOdd   = mode_ff[`SSF_MODE_ODD];
                end
            end
            ssf_pkg::RX_START: begin
                if (ovsTick && rxOvs_ff == `SSF_OVS_MID) begin
                    // a glitch that is high again at mid bit is not a start
                    nxt_rxState = rxd ? ssf_pkg::RX_IDLE : ssf_pkg::RX_DATA;
                    nxt_rxOvs   = 4'h0;
                end
            end
            ssf_pkg::RX_DATA: begin
                if (rxSample) begin
                    nxt_rxShift = {rxd, rxShift_ff[7:1]};
                    nxt_rxOnes  = rxOnes_ff ^ rxd;
                    nxt_rxCnt   = rxCnt_ff + 4'h1;
                    if (rxCnt_ff == rxLen_ff - 4'h1) begin
                        nxt_rxState = rxParOn_ff ? ssf_pkg::RX_PAR : ssf_pkg::RX_STOP;
                    end
                end
            end
            ssf_pkg::RX_PAR: begin
                if (rxSample) begin
                    rxPerr      = (rxOnes_ff ^ rxd) != rxOdd_ff;
                    nxt_rxState = ssf_pkg::RX_STOP;
                end
            end
            ssf_pkg::RX_STOP: begin
                if (rxSample) begin
                    rxFerr      = !rxd;
                    rxDone      = 1'b1;
                    nxt_rxData  = rxShift_ff >> (4'h8 - rxLen_ff);
                    nxt_rxState = ssf_pkg::RX_IDLE;
                end
            end
            default: nxt_rxState = ssf_pkg::RX_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rxState_ff <= ssf_pkg::RX_IDLE;
            rxOvs_ff   <= 4'h0;
            rxCnt_ff   <= 4'h0;
            rxLen_ff   <= `SSF_LEN_EIGHT;
            rxShift_ff <= 8'h00;
            rxOnes_ff  <= 1'b0;
            rxOdd_ff   <= 1'b0;
            rxParOn_ff <= 1'b0;
            rxData_ff  <= 8'h00;
        end else begin
            rxState_ff <= nxt_rxState;
            rxOvs_ff   <= nxt_rxOvs;
            rxCnt_ff   <= nxt_rxCnt;
            rxLen_ff   <= nxt_rxLen;
            rxShift_ff <= nxt_rxShift;
            rxOnes_ff  <= nxt_rxOnes;
            rxOdd_ff   <= nxt_rxOdd;
            rxParOn_ff <= nxt_rxParOn;
            rxData_ff  <= nxt_rxData;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_tx_parity_bit;
        @(posedge clk) disable iff (!rst_b)
        (txState_ff == ssf_pkg::TX_PAR) |-> ((txOnes_ff ^ txd) == txOdd_ff);
    endproperty
    a_tx_parity_bit: assert property (p_tx_parity_bit) else $error("parity bit sense wrong");

    property p_no_parity_when_off;
        @(posedge clk) disable iff (!rst_b)
        (txState_ff == ssf_pkg::TX_DATA && txBitEnd && txCnt_ff == txLen_ff - 4'h1 && !txParOn_ff)
            |=> (txState_ff == ssf_pkg::TX_STOP1);
    endproperty
    a_no_parity_when_off: assert property (p_no_parity_when_off) else $error("parity sent while off");

    property p_one_stop;
        @(posedge clk) disable iff (!rst_b)
        (txState_ff == ssf_pkg::TX_STOP1 && txBitEnd && !txStop2_ff) |=> (txState_ff == ssf_pkg::TX_IDLE && txd);
    endproperty
    a_one_stop: assert property (p_one_stop) else $error("single stop frame overran");

    property p_two_stop;
        @(posedge clk) disable iff (!rst_b)
        (txState_ff == ssf_pkg::TX_STOP2) |-> (txStop2_ff && txd);
    endproperty
    a_two_stop: assert property (p_two_stop) else $error("second stop without stop field");

    property p_ferr_first_stop;
        @(posedge clk) disable iff (!rst_b)
        $rose(sts_ff[`SSF_ST_FERR]) |-> ($past(rxState_ff) == ssf_pkg::RX_STOP && !$past(rxd));
    endproperty
    a_ferr_first_stop: assert property (p_ferr_first_stop) else $error("framing error not from first stop");

    property p_rx_rearm;
        @(posedge clk) disable iff (!rst_b)
        (rxState_ff == ssf_pkg::RX_STOP && rxSample) |=> (rxState_ff == ssf_pkg::RX_IDLE);
    endproperty
    a_rx_rearm: assert property (p_rx_rearm) else $error("receiver not rearmed after stop");

    property p_five_bits;
        @(posedge clk) disable iff (!rst_b)
        (txState_ff == ssf_pkg::TX_DATA && txLen_ff == `SSF_LEN_FIVE) |-> (txCnt_ff < 4'h5);
    endproperty
    a_five_bits: assert property (p_five_bits) else $error("more than five bits sent");

    property p_sys_source;
        @(posedge clk) disable iff (!rst_b)
        (mode_ff[1:0] == 2'b00) |-> srcTick;
    endproperty
    a_sys_source: assert property (p_sys_source) else $error("system clock source idle");

    property p_sub_gate;
        @(posedge clk) disable iff (!rst_b)
        (srcTick && mode_ff[1:0] != 2'b00) |-> (mode_ff[1:0] == 2'b01 && ctrl_ff[`SSF_CTRL_CPUSUB] && subTick);
    endproperty
    a_sub_gate: assert property (p_sub_gate) else $error("tick from gated or reserved source");

    property p_irq_level;
        @(posedge clk) disable iff (!rst_b)
        ((sts_ff & ien_ff) != 4'h0) |=> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");
endmodule : ssf_top
`default_nettype wire

/* tb_ssf_top.sv */
// self-checking bench for the frame format block
`include "ssf_consts.svh"
`default_nettype none
module tb_ssf_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_b, cyc, stb, we, ack, subTick, rxd, txd, irq;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat, dato, q;
    int          err_total, compares;
    ssf_top u_ssf_top (
        .clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dato), .wb_ack_o(ack), .subTick(subTick),
        .rxd(rxd), .txd(txd), .irq(irq));
    ssf_station u_ssf_station (.clk(clk), .txd(txd), .rxd(rxd));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = dato;
        cyc <= 1'b0; stb <= 1'b0;
    endtask : wb
    task automatic t_tx(input logic [7:0] m, input logic [7:0] d, input int n, input int pe, input int st);
        logic [15:0] fr, ex;
        logic        p;
        ex = '0;
        p = m[4];
        for (int i = 0; i < n; i++) begin
            ex[i+1] = d[i];
            p ^= d[i];
        end
        if (pe != 0) ex[n+1] = p;
        ex[n+pe+1] = 1'b1;
        wb(1'b1, `SSF_OFF_CLR, 32'h0000000F);
        wb(1'b1, `SSF_OFF_MODE, {24'h000000, m});
        wb(1'b1, `SSF_OFF_DATA, {24'h000000, d});
        u_ssf_station.grab(n + pe + 2, fr);
        chk("tx frame", {16'h0000, ex}, {16'h0000, fr});
        // second stop still running here, so done only shows for one stop
        repeat (12) @(posedge clk);
        wb(1'b0, `SSF_OFF_STAT, 32'h00000000);
        chk("tx done", (st == 1) ? 32'h00000001 : 32'h00000000, {31'h00000000, q[0]});
        // let a second stop run out before the next test clears status
        repeat (16) @(posedge clk);
        wb(1'b0, `SSF_OFF_STAT, 32'h00000000);
        chk("tx done end", 32'h00000001, {31'h00000000, q[0]});
        $display("tx test done mode %h", m);
    endtask : t_tx
    task automatic t_rx(input logic [7:0] m, input logic [23:0] b, input int n, input logic [31:0] es,
                        input logic [31:0] ed);
        wb(1'b1, `SSF_OFF_CLR, 32'h0000000F);
        wb(1'b1, `SSF_OFF_MODE, {24'h000000, m});
        u_ssf_station.send(b, n);
        repeat (20) @(posedge clk);
        wb(1'b0, `SSF_OFF_STAT, 32'h00000000);
        chk("rx status", es, q);
        wb(1'b0, `SSF_OFF_DATA, 32'h00000000);
        chk("rx data", ed, q);
        $display("rx test done mode %h", m);
    endtask : t_rx
    task automatic t_irq;
        wb(1'b1, `SSF_OFF_IEN, 32'h00000004);
        repeat (2) @(posedge clk);
        chk("irq raised", 32'h00000001, {31'h00000000, irq});
        wb(1'b1, `SSF_OFF_IEN, 32'h00000000);
        repeat (2) @(posedge clk);
        chk("irq masked", 32'h00000000, {31'h00000000, irq});
        wb(1'b1, `SSF_OFF_IEN, 32'h00000004);
        wb(1'b1, `SSF_OFF_CLR, 32'h00000004);
        repeat (2) @(posedge clk);
        chk("irq cleared", 32'h00000000, {31'h00000000, irq});
        $display("irq test done");
    endtask : t_irq
    task automatic t_clk(input logic [3:0] c, input logic [7:0] m, input int p);
        int   k;
        logic fits;
        k = 0;
        subTick <= 1'b1;
        wb(1'b1, `SSF_OFF_CTRL, {28'h0000000, c});
        wb(1'b1, `SSF_OFF_MODE, {24'h000000, m});
        wb(1'b1, `SSF_OFF_DATA, 32'h000000FF);
        while (txd !== 1'b0 && k < 20) begin
            @(posedge clk);
            k++;
        end
        k = 0;
        while (txd === 1'b0 && k < 2000) begin
            @(posedge clk);
            k++;
        end
        // start bit is 16 ticks of p clocks less the first tick's phase; p 0 means frozen
        fits = (p == 0) ? (k == 2000) : (k > 15 * p && k <= 16 * p);
        chk("start bit clocks", 32'h00000001, {31'h00000000, fits});
        repeat (160 * p) @(posedge clk);
        $display("clock test done select %h", m);
    endtask : t_clk
    task automatic report_and_stop;
        $display("mismatches %0d comparisons %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #400000;
        err_total++;
        report_and_stop;
    end
    initial begin
        rst_b = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'hF; dat = 32'h00000000;
        subTick = 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        wb(1'b0, `SSF_OFF_MODE, 32'h00000000);
        chk("mode reset", 32'h00000000, q);
        wb(1'b1, 8'h1C, 32'h000000FF);
        wb(1'b0, 8'h1C, 32'h00000000);
        chk("unmapped read", 32'h00000000, q);
        wb(1'b1, `SSF_OFF_CTRL, 32'h00000003);
        t_tx(8'h20, 8'hA5, 8, 1, 1);
        t_tx(8'h30, 8'hA5, 8, 1, 1);
        t_tx(8'h10, 8'h3C, 8, 0, 1);
        t_tx(8'h2C, 8'hF3, 5, 1, 2);
        t_tx(8'hB8, 8'h81, 8, 0, 1);
        t_rx(8'h28, 24'h2334B4, 22, 32'h00000002, 32'h00000033);
        t_rx(8'h00, 24'h0000B4, 10, 32'h0000000A, 32'h0000005A);
        t_rx(8'h30, 24'h0004B4, 11, 32'h00000006, 32'h0000005A);
        t_irq;
        t_clk(4'hF, 8'h01, 4);
        t_clk(4'hB, 8'h01, 8);
        t_clk(4'hF, 8'h02, 0);
        report_and_stop;
    end
endmodule : tb_ssf_top
`default_nettype wire
